// ---- rtl/frs_sequencer.sv ----
// Purpose: run-time flash erase/program sequencer with unlock key and holding buffer
// Assumes: register strobes are one-cycle pulses synchronous to ref_clk
// Notes: flash array is outside; this block issues one op pulse and times the cycle
// Operation
// - op code 0010 with erase-select and enable set selects page erase.
// - start is refused unless key got 0x55 then 0xaa immediately before.
// - start after unlock launches erase; stall held; start bit self-clears at end.
// - row program data is staged in holding buffer, 64 instructions per row.
// - op code 0001 with erase-select clear and enable set selects row program.
// - start after unlock begins row write; stall until done; start bit self-clears.
// - each buffered word is a low 16-bit write then high byte, then advance.
// - with enable clear, every program and erase is inhibited even on start.
// - error flag set on improper or aborted attempt, cleared when a start is accepted.
// - other erase codes bulk/segment/config; program codes word and config byte.
`timescale 1ns/1ns
module frs_sequencer #(
   parameter int ROW_CYCLES = frs_pkg::ROW_CYCLES,
   parameter int ERASE_CYCLES = frs_pkg::ERASE_CYCLES,
   parameter int WORD_CYCLES = frs_pkg::WORD_CYCLES
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // control register write port
   input wire logic ctrl_wr,
   input wire logic [3:0] operation_select,
   input wire logic erase_select,
   input wire logic program_erase_enable,
   input wire logic start_wr,
   // key register write port
   input wire logic key_wr,
   input wire logic [7:0] flash_unlock_key,
   // table write port
   input wire logic table_write_low_word,
   input wire logic table_write_high_byte,
   input wire logic [15:0] table_data,
   input wire logic [frs_pkg::PAGE_W-1:0] table_page_pointer,
   input wire logic [frs_pkg::ADDR_W-1:0] table_offset,
   input wire logic [frs_pkg::IDX_W-1:0] buffer_index,
   // control register readback
   output logic start_busy,
   output logic sequence_error_flag,
   output logic cpu_stall,
   // flash array side
   output logic flash_op_valid,
   output logic [3:0] flash_op_code,
   output logic flash_op_erase,
   output logic [frs_pkg::PAGE_W+frs_pkg::ADDR_W-1:0] flash_op_addr,
   output logic flash_wdata_valid,
   input wire logic flash_wdata_ready,
   output logic [frs_pkg::WORD_W-1:0] flash_wdata,
   output logic [frs_pkg::IDX_W-1:0] flash_wdata_index
);
   typedef struct packed {
      frs_pkg::frs_state_t state;
      frs_pkg::frs_key_t key;
      logic [3:0] op;
      logic erase;
      logic enable;
      logic busy;
      logic err;
      logic [15:0] low_hold;
      logic low_seen;
      logic [frs_pkg::PAGE_W+frs_pkg::ADDR_W-1:0] addr;
      logic [frs_pkg::CNT_W-1:0] timer;
      logic [frs_pkg::IDX_W-1:0] drain_idx;
      logic op_pulse;
   } frs_seq_t;
   frs_seq_t st;
   frs_seq_t next_st;
   logic fifo_in_valid;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [frs_pkg::WORD_W-1:0] fifo_out_data;
   logic launch;
   logic valid_op;

   // decode whether an op code is implemented under the erase/program selection
   function automatic logic op_legal(input logic [3:0] op, input logic erase);
      if (erase)
         op_legal = (op == frs_pkg::OP_BULK_ERASE) || (op == frs_pkg::OP_GEN_SEG_ERASE) ||
            (op == frs_pkg::OP_SEC_SEG_ERASE) || (op == frs_pkg::OP_PAGE_ERASE) ||
            (op == frs_pkg::OP_CFG_ERASE);
      else
         op_legal = (op == frs_pkg::OP_ROW_PROG) || (op == frs_pkg::OP_WORD_PROG) ||
            (op == frs_pkg::OP_CFG_PROG);
   endfunction

   // self-timed cycle length per operation
   function automatic logic [frs_pkg::CNT_W-1:0] op_time(input logic [3:0] op,
      input logic erase);
      if (erase)
         op_time = frs_pkg::CNT_W'(ERASE_CYCLES);
      else if (op == frs_pkg::OP_ROW_PROG)
         op_time = frs_pkg::CNT_W'(ROW_CYCLES);
      else
         op_time = frs_pkg::CNT_W'(WORD_CYCLES);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // holding buffer: a word enters on the high-byte write after its low word
   frs_fifo #(
      .WIDTH(frs_pkg::WORD_W),
      .DEPTH(frs_pkg::ROW_WORDS)
   ) u_hold (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .in_data({table_data[7:0], st.low_hold}),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );

   assign fifo_in_valid = table_write_high_byte && st.low_seen;
   assign fifo_out_ready = (st.state == frs_pkg::ST_LOAD) && flash_wdata_ready;
   assign flash_wdata_valid = (st.state == frs_pkg::ST_LOAD) && fifo_out_valid;
   assign flash_wdata = fifo_out_data;
   assign flash_wdata_index = st.drain_idx;
   assign valid_op = st.enable && op_legal(st.op, st.erase);
   assign launch = start_wr && !st.busy && st.key == frs_pkg::KEY_OPEN && valid_op;

   ////////////////////////////////////////////////////////////////////////////////
   // control, key tracking and sequencing
   always_comb
   begin
      next_st = st;
      next_st.op_pulse = 1'b0;
      // control fields are frozen while a cycle runs
      if (ctrl_wr && !st.busy)
      begin
         next_st.op = operation_select;
         next_st.erase = erase_select;
         next_st.enable = program_erase_enable;
      end
      // any key write that is not the next expected byte closes the lock
      if (key_wr)
      begin
         if (flash_unlock_key == frs_pkg::KEY_FIRST)
            next_st.key = frs_pkg::KEY_HALF;
         else if (flash_unlock_key == frs_pkg::KEY_SECOND && st.key == frs_pkg::KEY_HALF)
            next_st.key = frs_pkg::KEY_OPEN;
         else
            next_st.key = frs_pkg::KEY_IDLE;
      end
      else if (ctrl_wr || start_wr)
         next_st.key = frs_pkg::KEY_IDLE;
      // word pairing: low half held until its high byte arrives
      if (table_write_low_word)
      begin
         next_st.low_hold = table_data;
         next_st.low_seen = 1'b1;
      end
      else if (fifo_in_valid && fifo_in_ready)
         next_st.low_seen = 1'b0;
      if (table_write_low_word || table_write_high_byte)
         next_st.addr = {table_page_pointer, table_offset};
      // a refused start marks the error flag
      if (start_wr && !st.busy && !launch)
         next_st.err = 1'b1;
      unique case (st.state)
         frs_pkg::ST_IDLE:
         begin
            if (launch)
            begin
               next_st.busy = 1'b1;
               next_st.err = 1'b0;
               next_st.op_pulse = 1'b1;
               next_st.drain_idx = '0;
               next_st.timer = op_time(st.op, st.erase);
               if (!st.erase && st.op == frs_pkg::OP_ROW_PROG)
                  next_st.state = frs_pkg::ST_LOAD;
               else
                  next_st.state = frs_pkg::ST_BUSY;
            end
         end
         frs_pkg::ST_LOAD:
         begin
            // move buffered words to the array latches, then time the row write
            if (fifo_out_valid && flash_wdata_ready)
               next_st.drain_idx = st.drain_idx + 1'b1;
            if (!fifo_out_valid)
               next_st.state = frs_pkg::ST_BUSY;
         end
         frs_pkg::ST_BUSY:
         begin
            if (!st.enable)
            begin
               next_st.err = 1'b1;
               next_st.state = frs_pkg::ST_DONE;
            end
            else if (st.timer <= frs_pkg::CNT_W'(1))
               next_st.state = frs_pkg::ST_DONE;
            else
               next_st.timer = st.timer - 1'b1;
         end
         frs_pkg::ST_DONE:
         begin
            next_st.busy = 1'b0;
            next_st.state = frs_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         st <= '0;
      else
         st <= next_st;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs from the state register
   assign start_busy = st.busy;
   assign sequence_error_flag = st.err;
   assign cpu_stall = st.busy;
   assign flash_op_valid = st.op_pulse;
   assign flash_op_code = st.op;
   assign flash_op_erase = st.erase;
   assign flash_op_addr = st.addr;
endmodule

// ---- rtl/frs_pkg.sv ----
// Purpose: shared constants for the flash row erase/program sequencer
// Assumes: 125 MHz ref_clk
// Notes: op timings are nominal self-timed figures, shortened via top parameters
package frs_pkg;
   // operation-select codes, erase-select set
   localparam logic [3:0] OP_BULK_ERASE = 4'hf;
   localparam logic [3:0] OP_GEN_SEG_ERASE = 4'hd;
   localparam logic [3:0] OP_SEC_SEG_ERASE = 4'hc;
   localparam logic [3:0] OP_PAGE_ERASE = 4'h2;
   localparam logic [3:0] OP_CFG_ERASE = 4'h0;
   // operation-select codes, erase-select clear
   localparam logic [3:0] OP_WORD_PROG = 4'h3;
   localparam logic [3:0] OP_ROW_PROG = 4'h1;
   localparam logic [3:0] OP_CFG_PROG = 4'h0;
   // unlock key bytes
   localparam logic [7:0] KEY_FIRST = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'haa;
   // geometry
   localparam int ROW_WORDS = 64;
   localparam int IDX_W = 6;
   localparam int WORD_W = 24;
   localparam int PAGE_W = 8;
   localparam int ADDR_W = 16;
   // timing: clock and nominal cycle times
   localparam int CLK_MHZ = 125;
   localparam int ROW_TIME_US = 1586;
   localparam int ERASE_TIME_US = 24000;
   localparam int WORD_TIME_US = 55;
   localparam int ROW_CYCLES = ROW_TIME_US * CLK_MHZ;
   localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;
   localparam int WORD_CYCLES = WORD_TIME_US * CLK_MHZ;
   localparam int CNT_W = 32;
   // key tracker and sequencer states
   typedef enum logic [1:0] {KEY_IDLE = 2'b00, KEY_HALF = 2'b01, KEY_OPEN = 2'b11} frs_key_t;
   typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_LOAD = 2'b01, ST_BUSY = 2'b11,
      ST_DONE = 2'b10} frs_state_t;
endpackage

// ---- rtl/frs_fifo.sv ----
// Purpose: flip-flop FIFO with valid/ready on both sides
// Assumes: single clock, depth a power of two
// Notes: full/empty from a separate occupancy count
`timescale 1ns/1ns
module frs_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 32
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW-1:0] wr_ptr;
      logic [AW-1:0] rd_ptr;
      logic [AW:0] count;
   } frs_fifo_t;
   frs_fifo_t st;
   frs_fifo_t next_st;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push;
   logic pop;

   ////////////////////////////////////////////////////////////////////////////////
   // handshakes come from the registered count; a pop while full does not raise in_ready that cycle
   assign in_ready = (st.count != (AW + 1)'(DEPTH));
   assign out_valid = (st.count != '0);
   assign out_data = mem[st.rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // pointer and occupancy update
   always_comb
   begin
      next_st = st;
      if (push)
         next_st.wr_ptr = st.wr_ptr + 1'b1;
      if (pop)
         next_st.rd_ptr = st.rd_ptr + 1'b1;
      if (push && !pop)
         next_st.count = st.count + 1'b1;
      else if (pop && !push)
         next_st.count = st.count - 1'b1;
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         st <= '0;
      else
         st <= next_st;
   end

   // storage has no reset; only written entries are ever read
   always_ff @(posedge ref_clk)
   begin
      if (push)
         mem[st.wr_ptr] <= in_data;
   end
endmodule

// ---- test/frs_sequencer_props.sv ----
// Purpose: port-level checks of the flash sequencer
// Assumes: one clock, async active-low reset
// Notes: key and control state mirrored in helper logic
`timescale 1ns/1ns
module frs_sequencer_props #(
   parameter int ERASE_CYCLES = 10
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // requests
   input wire logic ctrl_wr,
   input wire logic [3:0] operation_select,
   input wire logic erase_select,
   input wire logic program_erase_enable,
   input wire logic start_wr,
   input wire logic key_wr,
   input wire logic [7:0] flash_unlock_key,
   // status and flash side
   input wire logic start_busy,
   input wire logic sequence_error_flag,
   input wire logic cpu_stall,
   input wire logic flash_op_valid,
   input wire logic [3:0] flash_op_code,
   input wire logic flash_op_erase,
   input wire logic flash_wdata_valid,
   input wire logic flash_wdata_ready,
   input wire logic [23:0] flash_wdata,
   input wire logic [5:0] flash_wdata_index
);
   logic [1:0] kst;
   logic [3:0] op;
   logic er, en, ok;
   int bcnt;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // mirror of key tracker, settings and busy length
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         kst <= 2'h0;
         op <= 4'h0;
         er <= 1'b0;
         en <= 1'b0;
         bcnt <= 0;
      end
      else
      begin
         if (key_wr)
            kst <= (flash_unlock_key == 8'h55) ? 2'h1 :
               (kst == 2'h1 && flash_unlock_key == 8'haa) ? 2'h2 : 2'h0;
         else if (ctrl_wr || start_wr)
            kst <= 2'h0;
         if (ctrl_wr && !start_busy)
         begin
            op <= operation_select;
            er <= erase_select;
            en <= program_erase_enable;
         end
         bcnt <= start_busy ? bcnt + 1 : 0;
      end
   end
   // reserved and no-operation codes count as illegal
   assign ok = er ? (op inside {4'hf, 4'hd, 4'hc, 4'h2, 4'h0}) : (op inside {4'h3, 4'h1, 4'h0});
   sequence s_launch;
      start_wr && !start_busy && kst == 2'h2 && en && ok;
   endsequence
   sequence s_answer;
      start_busy && flash_op_valid && !sequence_error_flag;
   endsequence
   a_start_launches: assert property (s_launch |=> s_answer)
      else $error("accepted start did not launch");
   a_start_refused: assert property (start_wr && !start_busy && !(kst == 2'h2 && en && ok)
      |=> sequence_error_flag && !start_busy)
      else $error("start without unlock was not refused");
   a_stall_tracks_busy: assert property (cpu_stall == start_busy)
      else $error("stall differs from busy");
   a_op_single_pulse: assert property (flash_op_valid |=> !flash_op_valid && start_busy)
      else $error("op pulse too long");
   a_op_code_match: assert property (flash_op_valid |-> flash_op_code == op &&
      flash_op_erase == er)
      else $error("op code differs from selection");
   a_erase_time: assert property ($fell(start_busy) && flash_op_erase |->
      bcnt >= ERASE_CYCLES + 1 && bcnt <= ERASE_CYCLES + 2)
      else $error("erase cycle length wrong");
   a_wdata_held: assert property (flash_wdata_valid && !flash_wdata_ready |=>
      flash_wdata_valid && $stable(flash_wdata) && $stable(flash_wdata_index))
      else $error("write data dropped while stalled");
   a_index_steps: assert property (flash_wdata_valid && flash_wdata_ready |=>
      flash_wdata_index == 6'($past(flash_wdata_index) + 1))
      else $error("buffer index did not advance");
   a_stream_busy: assert property (flash_wdata_valid |-> start_busy)
      else $error("write data outside a cycle");
endmodule
bind frs_sequencer frs_sequencer_props #(.ERASE_CYCLES(ERASE_CYCLES)) u_props (.ref_clk, .rst_n,
   .ctrl_wr, .operation_select, .erase_select, .program_erase_enable, .start_wr, .key_wr,
   .flash_unlock_key, .start_busy, .sequence_error_flag, .cpu_stall, .flash_op_valid,
   .flash_op_code, .flash_op_erase, .flash_wdata_valid, .flash_wdata_ready, .flash_wdata,
   .flash_wdata_index);

// ---- test/frs_flash_model.sv ----
// Purpose: flash array stand-in taking row data
// Assumes: words land by buffer index
// Notes: ready drops at random to stall the drain
`timescale 1ns/1ns
module frs_flash_model (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // launch and write stream
   input wire logic flash_op_valid,
   input wire logic flash_wdata_valid,
   input wire logic [23:0] flash_wdata,
   input wire logic [5:0] flash_wdata_index,
   output logic flash_wdata_ready
);
   logic [23:0] words [64];
   int count;
   int seed = 2379;
   // take one word per handshake, restart count per launch
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         flash_wdata_ready <= 1'b0;
         count <= 0;
      end
      else
      begin
         flash_wdata_ready <= ($random(seed) & 3) != 0;
         // the first word can be taken in the very cycle of the launch pulse
         if (flash_wdata_valid && flash_wdata_ready)
         begin
            words[flash_wdata_index] <= flash_wdata;
            count <= (flash_op_valid ? 0 : count) + 1;
         end
         else if (flash_op_valid)
            count <= 0;
      end
   end
endmodule

// ---- test/frs_sequencer_tb_top.sv ----
// Purpose: self-checking bench for the flash sequencer
// Assumes: cycle parameters set to 10
// Notes: row data random from a fixed seed
`timescale 1ns/1ns
module frs_sequencer_tb_top;
   logic ref_clk, rst_n, ctrl_wr, erase_select, program_erase_enable, start_wr, key_wr;
   logic table_write_low_word, table_write_high_byte, start_busy, sequence_error_flag, rer;
   logic cpu_stall, flash_op_valid, flash_op_erase, flash_wdata_valid, flash_wdata_ready;
   logic [3:0] operation_select, flash_op_code, rop;
   logic [7:0] flash_unlock_key, table_page_pointer;
   logic [15:0] table_data, table_offset;
   logic [5:0] buffer_index, flash_wdata_index;
   logic [23:0] flash_op_addr, flash_wdata, last_addr, exp_w [64];
   logic [3:0] codes [7] = '{4'hf, 4'hd, 4'hc, 4'h2, 4'h0, 4'h3, 4'h0};
   int miscompares, n_tests, seed, i, n, r;
   frs_sequencer #(.ROW_CYCLES(10), .ERASE_CYCLES(10), .WORD_CYCLES(10)) dut (.ref_clk,
      .rst_n, .ctrl_wr, .operation_select, .erase_select, .program_erase_enable, .start_wr,
      .key_wr, .flash_unlock_key, .table_write_low_word, .table_write_high_byte, .table_data,
      .table_page_pointer, .table_offset, .buffer_index, .start_busy, .sequence_error_flag,
      .cpu_stall, .flash_op_valid, .flash_op_code, .flash_op_erase, .flash_op_addr,
      .flash_wdata_valid, .flash_wdata_ready, .flash_wdata, .flash_wdata_index);
   frs_flash_model flm (.ref_clk, .rst_n, .flash_op_valid, .flash_wdata_valid, .flash_wdata,
      .flash_wdata_index, .flash_wdata_ready);
   initial
   begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   task automatic chk(input logic [23:0] s, input logic [23:0] e);
      n_tests++;
      if (s !== e)
      begin
         miscompares++;
         $display("ERROR %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   // implemented codes under each erase/program selection
   function automatic logic exp_legal(input logic [3:0] op, input logic er);
      if (er)
         exp_legal = op inside {4'hf, 4'hd, 4'hc, 4'h2, 4'h0};
      else
         exp_legal = op inside {4'h3, 4'h1, 4'h0};
   endfunction
   task automatic test_done;
      $display("tests %0d miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic setup(input logic [3:0] op, input logic er, input logic en);
      @(posedge ref_clk);
      ctrl_wr <= 1'b1;
      operation_select <= op;
      erase_select <= er;
      program_erase_enable <= en;
      @(posedge ref_clk);
      ctrl_wr <= 1'b0;
   endtask
   task automatic key(input logic [7:0] k);
      @(posedge ref_clk);
      key_wr <= 1'b1;
      flash_unlock_key <= k;
      @(posedge ref_clk);
      key_wr <= 1'b0;
   endtask
   // start bit write; a refused start must leave busy low and flag the error
   task automatic launch(input logic ok);
      @(posedge ref_clk);
      start_wr <= 1'b1;
      @(posedge ref_clk);
      start_wr <= 1'b0;
      #1;
      chk(24'(start_busy), 24'(ok));
      chk(24'(sequence_error_flag), 24'(!ok));
      for (i = 0; i < 1000 && start_busy === 1'b1; i++)
         @(negedge ref_clk);
      chk(24'(start_busy), 24'h0);
      chk(24'(sequence_error_flag), 24'(!ok));
   endtask
   // one buffered word: low half then high byte, offset random
   task automatic load(input logic [23:0] w, input logic lo, input logic [7:0] pg);
      @(posedge ref_clk);
      table_write_low_word <= lo;
      table_data <= w[15:0];
      table_page_pointer <= pg;
      table_offset <= 16'($random(seed));
      @(posedge ref_clk);
      last_addr = {table_page_pointer, table_offset};
      table_write_low_word <= 1'b0;
      table_write_high_byte <= 1'b1;
      table_data <= {8'h00, w[23:16]};
      @(posedge ref_clk);
      table_write_high_byte <= 1'b0;
   endtask
   initial
   begin
      {ctrl_wr, erase_select, program_erase_enable, start_wr, key_wr} = '0;
      {table_write_low_word, table_write_high_byte, table_page_pointer, table_data} = '0;
      {operation_select, flash_unlock_key, table_offset, buffer_index} = '0;
      seed = 2379;
      rst_n = 1'b0;
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      setup(4'h2, 1'b1, 1'b1);
      launch(1'b0);
      key(8'h55);
      key(8'haa);
      setup(4'h2, 1'b1, 1'b1);
      launch(1'b0);
      setup(4'h2, 1'b1, 1'b0);
      key(8'h55);
      key(8'haa);
      launch(1'b0);
      setup(4'he, 1'b1, 1'b1);
      key(8'h55);
      key(8'haa);
      launch(1'b0);
      // every legal non-row code, then a start that reuses the spent key
      for (n = 0; n < 7; n++)
      begin
         setup(codes[n], n < 5, 1'b1);
         key(8'h55);
         key(8'haa);
         launch(1'b1);
         chk({flash_op_erase, flash_op_code}, {19'h0, n < 5, codes[n]});
         launch(1'b0);
      end
      // eight full rows go to pages 0 to 7, page pointer advancing each row;
      // each row starts with a stray high byte that must not enter the buffer
      for (r = 0; r < 8; r++)
      begin
         setup(4'h1, 1'b0, 1'b1);
         load(24'hffffff, 1'b0, 8'(r));
         for (n = 0; n < 64; n++)
         begin
            exp_w[n] = 24'($random(seed));
            load(exp_w[n], 1'b1, 8'(r));
         end
         key(8'h55);
         key(8'haa);
         launch(1'b1);
         chk(flash_op_addr, last_addr);
         chk(24'(flm.count), 24'd64);
         for (n = 0; n < 64; n++)
            chk(flm.words[n], exp_w[n]);
      end
      // random codes under a fresh key: reserved and no-op codes are refused
      for (n = 0; n < 12; n++)
      begin
         rop = 4'($random(seed));
         rer = 1'($random(seed));
         setup(rop, rer, 1'b1);
         key(8'h55);
         key(8'haa);
         launch(exp_legal(rop, rer));
         chk({flash_op_erase, flash_op_code}, {19'h0, rer, rop});
      end
      test_done;
   end
   // hang guard well past the expected run
   initial
   begin
      #200000;
      miscompares++;
      test_done;
   end
endmodule
